// [src/crb_reset_ctrl.sv]
`timescale 1ns/1ps
`include "crb_map.svh"

// Overview of operation
// - Hardware reset pin low resets core functions and peripheral modules.
// - While reset pin low, modules disabled and registers at defaults.
// - Boot begins only after the reset pin is released.
// - Interrupt pin driven low when ready for software download.
// - Interrupt pin released high when the boot sequence completes.
// - Reference clock input is the default clock source after reset.
// - Any enabled, unmasked trigger causes a warm reset.
// - Warm reset resets peripherals only; configuration survives.
// - Debug reset input low causes warm reset unless its mask is set.
// - Watchdog timeout resets only when enabled and not masked.
// - PLL out-of-lock causes warm reset unless its mask is set.
// - Masked interrupt status bits drive the separate irq output, active high.
// - Fast wake request causes warm reset only when wake enable set.
// - Interrupt stays asserted until software fully downloaded.
module crb_reset_ctrl (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire crb_pkg::crb_trig_t trig,
    output crb_pkg::crb_rst_t     rst_out,
    output logic                  irq_pin_n,
    output logic                  irq
);
    import crb_pkg::*;

    // ************************************************************
    // Trigger synchronisers
    // ************************************************************
    crb_trig_t trig_m;
    crb_trig_t trig_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_m <= '{1'b1, 1'b0, 1'b0, 1'b1};
            trig_s <= '{1'b1, 1'b0, 1'b0, 1'b1};
        end
        else
        begin
            trig_m <= trig;
            trig_s <= trig_m;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [4:0]        ctrl;
    logic [2:0]        mask;
    logic [`CRB_EV_W-1:0] irq_stat;
    logic [`CRB_EV_W-1:0] irq_mask;
    crb_boot_t         boot;
    logic [3:0]        st_cnt;
    logic [1:0]        warm_cnt;
    logic              warm_act;
    logic              warm_req;
    logic [`CRB_EV_W-1:0] events;
    logic              wr_en;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        return a == b;
    endfunction : hit

    assign wr_en = psel && penable && pready && pwrite;

    always_comb
    begin
        warm_req = (!trig_s.debug_warm_reset_n
                    && !mask[`CRB_MSK_DEBUG])
                 || (trig_s.watchdog_timeout && ctrl[`CRB_CTRL_WDT_EN]
                    && !mask[`CRB_MSK_WDT])
                 || (trig_s.pll_unlock && !mask[`CRB_MSK_PLL])
                 || (!trig_s.fast_wake_request_n
                    && ctrl[`CRB_CTRL_WAKE_EN]);
    end

    // Configuration survives warm reset; only presetn clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= `CRB_CTRL_RST;
        else if (wr_en && hit(paddr, `CRB_ADDR_CTRL))
            ctrl <= pwdata[4:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask <= `CRB_MASK_RST;
        else if (wr_en && hit(paddr, `CRB_ADDR_MASK))
            mask <= pwdata[2:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= `CRB_IMASK_RST;
        else if (wr_en && hit(paddr, `CRB_ADDR_IRQ_MASK))
            irq_mask <= pwdata[`CRB_EV_W-1:0];
    end

    // ************************************************************
    // Warm reset pulse
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            warm_cnt <= 2'h0;
            warm_act <= 1'b0;
        end
        else if (warm_req)
        begin
            warm_cnt <= 2'(`CRB_WARM_MIN_CYC - 1);
            warm_act <= 1'b1;
        end
        else if (warm_cnt != 2'h0)
            warm_cnt <= warm_cnt - 2'h1;
        else
            warm_act <= 1'b0;
    end

    // ************************************************************
    // Boot sequencer
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            boot <= ST_RESET;
            st_cnt <= 4'h0;
        end
        else
        begin
            case (boot)
                ST_RESET:
                begin
                    boot <= ST_SELF;
                    st_cnt <= 4'(`CRB_SELFTEST_CYC - 1);
                end
                ST_SELF:
                    if (st_cnt == 4'h0)
                        boot <= ST_LOAD;
                    else
                        st_cnt <= st_cnt - 4'h1;
                ST_LOAD:
                    if (wr_en && hit(paddr, `CRB_ADDR_CTRL)
                        && pwdata[`CRB_CTRL_DONE])
                        boot <= ST_RUN;
                ST_RUN:
                    boot <= ST_RUN;
                default:
                    boot <= ST_RESET;
            endcase
        end
    end

    // ************************************************************
    // Pins and reset outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pin_n <= 1'b1;
            rst_out <= '{1'b0, 1'b0, 1'b0};
        end
        else
        begin
            irq_pin_n <= !(boot == ST_LOAD);
            rst_out.core_reset_n <= 1'b1;
            rst_out.peripheral_reset_n <= !warm_act;
            rst_out.clock_sel_pll <= ctrl[`CRB_CTRL_CLK_SEL];
        end
    end

    // ************************************************************
    // Interrupt status
    // ************************************************************
    always_comb
    begin
        events = '0;
        events[`CRB_EV_DEBUG] = !trig_s.debug_warm_reset_n;
        events[`CRB_EV_WDT]   = trig_s.watchdog_timeout;
        events[`CRB_EV_PLL]   = trig_s.pll_unlock;
        events[`CRB_EV_WAKE]  = !trig_s.fast_wake_request_n;
        events[`CRB_EV_READY] = (boot == ST_SELF) && (st_cnt == 4'h0);
        events[`CRB_EV_DONE]  = (boot == ST_LOAD) && wr_en
            && hit(paddr, `CRB_ADDR_CTRL) && pwdata[`CRB_CTRL_DONE];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= '0;
        else if (wr_en && hit(paddr, `CRB_ADDR_IRQ_STAT))
            irq_stat <= (irq_stat & ~pwdata[`CRB_EV_W-1:0]) | events;
        else
            irq_stat <= irq_stat | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_mask);
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (psel && !penable)
            begin
                case (paddr)
                    `CRB_ADDR_CTRL:     prdata <= {27'h0, ctrl};
                    `CRB_ADDR_MASK:     prdata <= {29'h0, mask};
                    `CRB_ADDR_STATUS:
                        prdata <= {26'h0, warm_act, boot,
                                   !irq_pin_n};
                    `CRB_ADDR_IRQ_STAT: prdata <= {26'h0, irq_stat};
                    `CRB_ADDR_IRQ_MASK: prdata <= {26'h0, irq_mask};
                    default:            pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_boot_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> boot == ST_RESET && irq_pin_n)
        else $error("boot started early");
    chk_irq_ready: assert property (
        @(posedge pclk) disable iff (!presetn)
        boot == ST_LOAD |=> !irq_pin_n)
        else $error("irq not low when ready");
    chk_irq_done: assert property (
        @(posedge pclk) disable iff (!presetn)
        boot == ST_RUN |=> irq_pin_n)
        else $error("irq not released");
    chk_warm_min: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(warm_act) |-> warm_act [*2])
        else $error("warm reset too short");
    chk_warm_pll: assert property (
        @(posedge pclk) disable iff (!presetn)
        trig_s.pll_unlock && !mask[`CRB_MSK_PLL] |=> warm_act)
        else $error("pll unlock ignored");
    chk_warm_dbg: assert property (
        @(posedge pclk) disable iff (!presetn)
        !trig_s.debug_warm_reset_n && !mask[`CRB_MSK_DEBUG]
        |=> ##1 !rst_out.peripheral_reset_n)
        else $error("debug reset ignored");
    chk_warm_wdt: assert property (
        @(posedge pclk) disable iff (!presetn)
        trig_s.watchdog_timeout && !warm_act
        && (!ctrl[`CRB_CTRL_WDT_EN] || mask[`CRB_MSK_WDT])
        && trig_s.debug_warm_reset_n && !trig_s.pll_unlock
        && (trig_s.fast_wake_request_n || !ctrl[`CRB_CTRL_WAKE_EN])
        |=> !warm_act)
        else $error("watchdog reset while disabled");
    chk_wake_req: assert property (
        @(posedge pclk) disable iff (!presetn)
        !trig_s.fast_wake_request_n && ctrl[`CRB_CTRL_WAKE_EN]
        |=> warm_act)
        else $error("wake reset ignored");
    chk_core_keep: assert property (
        @(posedge pclk) disable iff (!presetn)
        warm_act |=> rst_out.core_reset_n)
        else $error("core reset by warm reset");
    chk_dbg_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        !trig_s.debug_warm_reset_n && mask[`CRB_MSK_DEBUG] && !warm_act
        && !trig_s.watchdog_timeout && !trig_s.pll_unlock
        && trig_s.fast_wake_request_n
        |=> !warm_act)
        else $error("masked debug reset acted");
    chk_pll_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        trig_s.pll_unlock && mask[`CRB_MSK_PLL] && !warm_act
        && trig_s.debug_warm_reset_n && !trig_s.watchdog_timeout
        && trig_s.fast_wake_request_n
        |=> !warm_act)
        else $error("masked pll unlock acted");
    chk_wake_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        !trig_s.fast_wake_request_n && !ctrl[`CRB_CTRL_WAKE_EN]
        && !warm_act && trig_s.debug_warm_reset_n
        && !trig_s.watchdog_timeout && !trig_s.pll_unlock
        |=> !warm_act)
        else $error("wake reset while disabled");
    chk_periph_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        warm_act |=> !rst_out.peripheral_reset_n)
        else $error("peripherals not held in warm reset");
    chk_self_seq: assert property (
        @(posedge pclk) disable iff (!presetn)
        boot == ST_RESET |=> boot == ST_SELF)
        else $error("boot did not start after release");
    chk_load_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        boot == ST_LOAD && !events[`CRB_EV_DONE] |=> boot == ST_LOAD)
        else $error("download window closed early");
    chk_clk_ref: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ctrl[`CRB_CTRL_CLK_SEL] |=> !rst_out.clock_sel_pll)
        else $error("reference clock not selected");
    chk_apb_ready: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("no answer in access cycle");
    chk_apb_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held too long");
    chk_stat_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        events != '0 |=> (irq_stat & $past(events)) == $past(events))
        else $error("event lost in status");
    chk_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq_stat & irq_mask) != '0 |=> irq)
        else $error("interrupt not raised");

    cov_ready: cover property (@(posedge pclk) boot == ST_LOAD);
    cov_done: cover property (@(posedge pclk) boot == ST_RUN);
    cov_warm: cover property (@(posedge pclk) $rose(warm_act));
    cov_wdt_on: cover property (@(posedge pclk)
        trig_s.watchdog_timeout && ctrl[`CRB_CTRL_WDT_EN]);
    cov_bad_addr: cover property (@(posedge pclk) pready && pslverr);
endmodule : crb_reset_ctrl

// [src/crb_map.svh]
`ifndef CRB_MAP_SVH
`define CRB_MAP_SVH
// Register byte addresses
`define CRB_ADDR_CTRL      12'h000
`define CRB_ADDR_MASK      12'h004
`define CRB_ADDR_STATUS    12'h008
`define CRB_ADDR_IRQ_STAT  12'h00c
`define CRB_ADDR_IRQ_MASK  12'h010
// Control register fields
`define CRB_CTRL_READY     0
`define CRB_CTRL_DONE      1
`define CRB_CTRL_WDT_EN    2
`define CRB_CTRL_WAKE_EN   3
`define CRB_CTRL_CLK_SEL   4
// Mask register fields
`define CRB_MSK_DEBUG      0
`define CRB_MSK_WDT        1
`define CRB_MSK_PLL        2
// Event bit positions
`define CRB_EV_DEBUG       0
`define CRB_EV_WDT         1
`define CRB_EV_PLL         2
`define CRB_EV_WAKE        3
`define CRB_EV_READY       4
`define CRB_EV_DONE        5
`define CRB_EV_W           6
// Reset values
`define CRB_CTRL_RST       5'h00
`define CRB_MASK_RST       3'h0
`define CRB_IMASK_RST      6'h00
// Self-test time before download window opens
`define CRB_SELFTEST_NS    200
`define CRB_CLK_NS         20
`define CRB_SELFTEST_CYC   ((`CRB_SELFTEST_NS + `CRB_CLK_NS - 1) / `CRB_CLK_NS)
// Least warm reset pulse, in cycles
`define CRB_WARM_MIN_CYC   2
`endif

// [src/crb_pkg.sv]
package crb_pkg;
    typedef enum logic [3:0] {
        ST_RESET   = 4'b0001,
        ST_SELF    = 4'b0010,
        ST_LOAD    = 4'b0100,
        ST_RUN     = 4'b1000
    } crb_boot_t;

    typedef struct packed {
        logic debug_warm_reset_n;
        logic watchdog_timeout;
        logic pll_unlock;
        logic fast_wake_request_n;
    } crb_trig_t;

    typedef struct packed {
        logic peripheral_reset_n;
        logic core_reset_n;
        logic clock_sel_pll;
    } crb_rst_t;
endpackage : crb_pkg

// [testbench/crb_far_model.sv]
`timescale 1ns/1ps
// ****************************************
// Host, power sequencer and debug probe
// ****************************************
module crb_far_model
    import crb_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       hw_req,
    input  wire logic [3:0] act,
    output logic            presetn = 1'b0,
    output crb_trig_t       trig = 4'b1001
);
    // Reset pin low until the bench says supplies and clock are good
    always @(posedge pclk)
    begin
        presetn <= !hw_req;
    end
    // One-hot request in field order, turned into each line's level
    always @(posedge pclk)
    begin
        trig <= act ^ 4'b1001;
    end
endmodule : crb_far_model

// [testbench/chip_reset_and_boot_ready_control_tb_top.sv]
`timescale 1ns/1ps
`include "crb_map.svh"
module chip_reset_and_boot_ready_control_tb_top;
    import crb_pkg::*;
    logic        pclk = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        presetn;
    crb_trig_t   trig;
    crb_rst_t    rst_out;
    logic        irq_pin_n;
    logic        irq;
    logic        hw_req = 1'b1;
    logic [3:0]  act = 4'h0;
    logic [31:0] seed = 32'd76536;
    logic [31:0] rd;
    logic        er;
    logic        ex;
    logic [1:0]  k;
    logic [2:0]  ms;
    logic [4:0]  ct;
    int          lowc;
    int          fails = 0;
    int          compares = 0;
    int          cyc = 0;
    // ****************************************
    // Design and far side
    // ****************************************
    crb_reset_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig(trig),
        .rst_out(rst_out), .irq_pin_n(irq_pin_n), .irq(irq));
    crb_far_model u_far (.pclk(pclk), .hw_req(hw_req), .act(act),
        .presetn(presetn), .trig(trig));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    function automatic logic ex_warm(input logic [1:0] t,
        input logic [2:0] m, input logic [4:0] c);
        case (t)
            2'd0: return !m[0];
            2'd1: return c[2] && !m[1];
            2'd2: return !m[2];
            default: return c[3];
        endcase
    endfunction : ex_warm
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
    begin
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    end
    endtask : apb
    task automatic close_out();
    begin
        $display("Counts: compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    end
    endtask : close_out
    // ****************************************
    // Clock, timeout and tests
    // ****************************************
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        chk({29'h0, rst_out, irq_pin_n}, 32'h1);
        hw_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({29'h0, rst_out, irq_pin_n}, 32'hd);
        apb(1'b0, `CRB_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `CRB_ADDR_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        repeat (40) if (irq_pin_n !== 1'b0) @(posedge pclk);
        chk(32'(irq_pin_n), 32'h0);
        apb(1'b0, `CRB_ADDR_STATUS, 32'h0);
        chk({28'h0, rd[4:1]}, {28'h0, ST_LOAD});
        $display("[TEST] boot done");
        apb(1'b1, `CRB_ADDR_IRQ_MASK, 32'h10);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1);
        apb(1'b1, `CRB_ADDR_IRQ_STAT, 32'h3f);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        $display("[TEST] irq done");
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            k = (i < 4) ? 2'(i) : seed[1:0];
            ms = (i < 4) ? 3'h0 : seed[4:2];
            ct = (i < 4) ? 5'h0c : {seed[7:5], 2'b00};
            ex = ex_warm(k, ms, ct);
            apb(1'b1, `CRB_ADDR_MASK, {29'h0, ms});
            apb(1'b1, `CRB_ADDR_CTRL, {27'h0, ct});
            act <= 4'b1000 >> k;
            lowc = 0;
            for (int j = 0; j < 24; j++)
            begin
                @(posedge pclk);
                if (j == 6) act <= 4'h0;
                if (rst_out.peripheral_reset_n === 1'b0) lowc++;
            end
            chk(32'(lowc != 0), 32'(ex));
            chk(32'(lowc > 1), 32'(ex));
            apb(1'b0, `CRB_ADDR_CTRL, 32'h0);
            chk(rd & 32'h1c, {27'h0, ct});
            chk(32'(rst_out.clock_sel_pll), 32'(ct[4]));
            apb(1'b0, `CRB_ADDR_IRQ_STAT, 32'h0);
            chk(32'(rd[k]), 32'h1);
            apb(1'b1, `CRB_ADDR_IRQ_STAT, 32'h3f);
        end
        $display("[TEST] warm done");
        chk(32'(irq_pin_n), 32'h0);
        apb(1'b1, `CRB_ADDR_CTRL, 32'h2);
        repeat (2) @(posedge pclk);
        chk(32'(irq_pin_n), 32'h1);
        hw_req <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({29'h0, rst_out, irq_pin_n}, 32'h1);
        hw_req <= 1'b0;
        apb(1'b0, `CRB_ADDR_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `CRB_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        repeat (40) if (irq_pin_n !== 1'b0) @(posedge pclk);
        chk(32'(irq_pin_n), 32'h0);
        $display("[TEST] rerun done");
        close_out();
    end
endmodule : chip_reset_and_boot_ready_control_tb_top
